// ---- design/charger_option_pkg.sv ----
// constants for the two charger option registers and adapter deglitch
// assumes one 250 MHz clock and a register port fed by the smbus engine
// Behaviour
// - select 0: limits from registers only
// - select 1: smaller of pin and register
// - bit 15 gates discharge regulation, reset 0
// - first insertion after reset: 150 ms deglitch
// - later insertions: 150 ms or 1.3 s
// - short on detect pin: switches off 1.3 s
// - bit 11 read-only, mirrors adapter ok pin
package charger_option_pkg;
   localparam logic [7:0]  OPT3_ADDR      = 8'h37;
   localparam logic [7:0]  OPT2_ADDR      = 8'h38;
   localparam int          EXT_LIMIT_BIT  = 7;
   localparam int          DCHG_REG_BIT   = 15;
   localparam int          DEG_SEL_BIT    = 12;
   localparam int          PRESENT_BIT    = 11;
   localparam logic [15:0] OPT2_RESET     = 16'h0384;
   localparam logic [15:0] OPT2_WMASK     = 16'h0080;
   localparam logic [15:0] OPT3_RESET     = 16'h1240;
   localparam logic [15:0] OPT3_WMASK     = 16'h97FC;
   localparam int          CLK_MHZ        = 250;
   localparam int          DEG_SHORT_US   = 150000;
   localparam int          DEG_LONG_US    = 1300000;
   localparam int          DEG_SHORT_CYC  = DEG_SHORT_US * CLK_MHZ;
   localparam int          DEG_LONG_CYC   = DEG_LONG_US * CLK_MHZ;
   localparam int          DEG_CNT_W      = 29;
endpackage

// ---- design/rise_deglitch.sv ----
// rising-edge deglitch: output rises after input held high for limit
// assumes a synchronised input; falling edge clears the output on the next clock, with no count
module rise_deglitch
#(
   parameter int CNT_W = 29
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             level,
   input  wire logic [CNT_W-1:0] limit,
   output logic                  qualified_q
);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic             qualified_d;

   always_comb
   begin
      count_d     = count_q;
      qualified_d = qualified_q;
      if (!level)
      begin
         count_d     = '0;
         qualified_d = 1'b0;
      end
      else if (!qualified_q)
      begin
         // limit is re-read each cycle; a late select change still counts
         if (count_q + CNT_W'(1) >= limit)
            qualified_d = 1'b1;
         else
            count_d = count_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_q     <= '0;
         qualified_q <= 1'b0;
      end
      else
      begin
         count_q     <= count_d;
         qualified_q <= qualified_d;
      end
   end
endmodule

// ---- design/charger_option_registers.sv ----
// option registers, current limit selection and adapter-ok deglitch
// assumes the smbus engine gives one-cycle read and write strobes
module charger_option_registers
   import charger_option_pkg::*;
#(
   parameter int LIM_W     = 16,
   parameter int SHORT_CYC = DEG_SHORT_CYC,
   parameter int LONG_CYC  = DEG_LONG_CYC
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr,
   input  wire logic [15:0]      reg_wdata,
   input  wire logic             reg_rd,
   output logic      [15:0]      reg_rdata_q,
   output logic                  reg_rvalid_q,
   input  wire logic [LIM_W-1:0] charge_limit_reg,
   input  wire logic [LIM_W-1:0] discharge_limit_reg,
   input  wire logic [LIM_W-1:0] current_limit_pin,
   input  wire logic             adapter_detect_pin,
   input  wire logic             system_overcurrent,
   output logic      [LIM_W-1:0] charge_limit_q,
   output logic      [LIM_W-1:0] discharge_limit_q,
   output logic                  discharge_regulation_enable_q,
   output logic                  adapter_ok_pin_q,
   output logic                  adapter_switch_on_q,
   output logic                  reverse_block_switch_on_q
);
   function automatic logic [LIM_W-1:0] pick_limit
   (
      input logic             use_pin,
      input logic [LIM_W-1:0] reg_val,
      input logic [LIM_W-1:0] pin_val
   );
      if (use_pin && pin_val < reg_val)
         return pin_val;
      return reg_val;
   endfunction

   localparam logic [DEG_CNT_W-1:0] SHORT_LIM = DEG_CNT_W'(SHORT_CYC);
   localparam logic [DEG_CNT_W-1:0] LONG_LIM  = DEG_CNT_W'(LONG_CYC);

   logic [15:0]      opt2_q;
   logic [15:0]      opt2_d;
   logic [15:0]      opt3_q;
   logic [15:0]      opt3_d;
   logic [15:0]      rdata_d;
   logic [2:0]       det_sync_q;
   logic [2:0]       oc_sync_q;
   logic [2:0]       det_sync_d;
   logic [2:0]       oc_sync_d;
   logic             det_level_q;
   logic             det_level_d;
   logic             oc_level_q;
   logic             oc_level_d;
   logic             seen_first_q;
   logic             seen_first_d;
   logic             short_seen_q;
   logic             short_seen_d;
   logic [DEG_CNT_W-1:0] deg_limit;
   logic             adapter_ok;
   logic [LIM_W-1:0] chg_d;
   logic [LIM_W-1:0] dchg_d;

   // registers and read path
   always_comb
   begin
      opt2_d  = opt2_q;
      opt3_d  = opt3_q;
      rdata_d = reg_rdata_q;
      if (reg_wr && reg_addr == OPT2_ADDR)
         opt2_d = (OPT2_RESET & ~OPT2_WMASK) | (reg_wdata & OPT2_WMASK);
      if (reg_wr && reg_addr == OPT3_ADDR)
         opt3_d = (OPT3_RESET & ~OPT3_WMASK) | (reg_wdata & OPT3_WMASK);
      // data held between reads; unmapped reads give zero
      if (reg_rd)
      begin
         rdata_d = 16'h0000;
         if (reg_addr == OPT2_ADDR)
            rdata_d = opt2_q;
         else if (reg_addr == OPT3_ADDR)
         begin
            rdata_d = opt3_q;
            rdata_d[PRESENT_BIT] = adapter_ok_pin_q;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         opt2_q       <= OPT2_RESET;
         opt3_q       <= OPT3_RESET;
         reg_rdata_q  <= 16'h0000;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         opt2_q       <= opt2_d;
         opt3_q       <= opt3_d;
         reg_rvalid_q <= reg_rd;
         reg_rdata_q  <= rdata_d;
      end
   end

   // pin synchronisers: a change counts once stages two and three agree
   always_comb
   begin
      det_sync_d  = {det_sync_q[1:0], adapter_detect_pin};
      oc_sync_d   = {oc_sync_q[1:0], system_overcurrent};
      det_level_d = det_level_q;
      oc_level_d  = oc_level_q;
      if (det_sync_q[1] == det_sync_q[2])
         det_level_d = det_sync_q[2];
      if (oc_sync_q[1] == oc_sync_q[2])
         oc_level_d = oc_sync_q[2];
   end

   // insertion history and short tracking
   always_comb
   begin
      seen_first_d = seen_first_q;
      short_seen_d = short_seen_q;
      if (adapter_ok)
      begin
         seen_first_d = 1'b1;
         short_seen_d = 1'b0;
      end
      // set after clear: a short in the drop cycle still counts
      // detect low during overcurrent
      if (!det_level_q && oc_level_q && seen_first_q)
         short_seen_d = 1'b1;
   end

   always_comb
   begin
      if (!seen_first_q)
         deg_limit = SHORT_LIM;
      else if (short_seen_q)
         deg_limit = LONG_LIM;
      else if (opt3_q[DEG_SEL_BIT])
         deg_limit = LONG_LIM;
      else
         deg_limit = SHORT_LIM;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         det_sync_q   <= 3'h0;
         oc_sync_q    <= 3'h0;
         det_level_q  <= 1'b0;
         oc_level_q   <= 1'b0;
         seen_first_q <= 1'b0;
         short_seen_q <= 1'b0;
      end
      else
      begin
         det_sync_q   <= det_sync_d;
         oc_sync_q    <= oc_sync_d;
         det_level_q  <= det_level_d;
         oc_level_q   <= oc_level_d;
         seen_first_q <= seen_first_d;
         short_seen_q <= short_seen_d;
      end
   end

   rise_deglitch
   #(
      .CNT_W       (DEG_CNT_W)
   )
   u_deglitch
   (
      .clk         (clk),
      .rst         (rst),
      .level       (det_level_q),
      .limit       (deg_limit),
      .qualified_q (adapter_ok)
   );

   // limit selection; pin value assumed already on this clock
   always_comb
   begin
      chg_d  = pick_limit(opt2_q[EXT_LIMIT_BIT], charge_limit_reg,
                          current_limit_pin);
      dchg_d = pick_limit(opt2_q[EXT_LIMIT_BIT], discharge_limit_reg,
                          current_limit_pin);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         charge_limit_q                <= '0;
         discharge_limit_q             <= '0;
         discharge_regulation_enable_q <= 1'b0;
         adapter_ok_pin_q              <= 1'b0;
         adapter_switch_on_q           <= 1'b0;
         reverse_block_switch_on_q     <= 1'b0;
      end
      else
      begin
         charge_limit_q                <= chg_d;
         discharge_limit_q             <= dchg_d;
         discharge_regulation_enable_q <= opt3_q[DCHG_REG_BIT];
         adapter_ok_pin_q              <= adapter_ok;
         // one source for pin and switches so they never disagree
         // switches follow qualified adapter
         adapter_switch_on_q           <= adapter_ok;
         reverse_block_switch_on_q     <= adapter_ok;
      end
   end
endmodule

// ---- tb/charger_option_monitor.sv ----
// checker for the option register port, charge limit and adapter ok
// sees only the top ports; bound from the testbench top file
module charger_option_monitor
   import charger_option_pkg::*;
#(
   parameter int LIM_W     = 16,
   parameter int SHORT_CYC = 20
)
(
   input wire logic             clk,
   input wire logic             rst,
   input wire logic [7:0]       reg_addr,
   input wire logic             reg_wr,
   input wire logic [15:0]      reg_wdata,
   input wire logic             reg_rd,
   input wire logic [15:0]      reg_rdata_q,
   input wire logic             reg_rvalid_q,
   input wire logic [LIM_W-1:0] charge_limit_reg,
   input wire logic [LIM_W-1:0] current_limit_pin,
   input wire logic             adapter_detect_pin,
   input wire logic [LIM_W-1:0] charge_limit_q,
   input wire logic             discharge_regulation_enable_q,
   input wire logic             adapter_ok_pin_q,
   input wire logic             adapter_switch_on_q,
   input wire logic             reverse_block_switch_on_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       ext_q, ext_d, dchg_q, dchg_d;
   logic [7:0] hi_q, hi_d;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff rst;
   // shadow copies; counter saturates so long waits stay safe
   always_comb
   begin
      ext_d  = ext_q;
      dchg_d = dchg_q;
      if (reg_wr && reg_addr == OPT2_ADDR)
         ext_d = reg_wdata[EXT_LIMIT_BIT];
      if (reg_wr && reg_addr == OPT3_ADDR)
         dchg_d = reg_wdata[DCHG_REG_BIT];
      hi_d = !adapter_detect_pin ? 8'h00 : (&hi_q ? hi_q : hi_q + 8'h01);
   end
   always_ff @(posedge clk)
   begin
      ext_q  <= rst ? 1'b1 : ext_d;
      dchg_q <= rst ? 1'b0 : dchg_d;
      hi_q   <= rst ? 8'h00 : hi_d;
   end
   a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
      else $error("read answer missing");
   a_no_answer: assert property (!reg_rd |=> !reg_rvalid_q)
      else $error("read answer without request");
   a_rdata_hold: assert property
      (!reg_rvalid_q |-> $stable(reg_rdata_q))
      else $error("read data moved between reads");
   a_limit_select: assert property
      (!$past(rst) |-> charge_limit_q ==
      (($past(ext_q) && $past(current_limit_pin) < $past(charge_limit_reg))
      ? $past(current_limit_pin) : $past(charge_limit_reg)))
      else $error("charge limit wrong");
   a_dchg_follow: assert property ((!$past(rst) && $stable(dchg_q))
      |-> discharge_regulation_enable_q == dchg_q)
      else $error("discharge enable wrong");
   a_switch_tie: assert property
      (adapter_switch_on_q == adapter_ok_pin_q
      && reverse_block_switch_on_q == adapter_ok_pin_q)
      else $error("switches differ from adapter ok");
   a_ok_drop: assert property
      (!adapter_detect_pin [*8] |-> !adapter_ok_pin_q)
      else $error("adapter ok stayed high");
   a_rise_deglitch: assert property
      ($rose(adapter_ok_pin_q) |-> hi_q >= SHORT_CYC)
      else $error("adapter ok rose too early");
   a_reset_quiet: assert property
      ($past(rst) |-> !adapter_ok_pin_q && !reg_rvalid_q)
      else $error("outputs active after reset");
   c_ok_rise: cover property ($rose(adapter_ok_pin_q));
   c_opt2_write: cover property (reg_wr && reg_addr == OPT2_ADDR);
   c_read: cover property (reg_rvalid_q);
endmodule

// ---- tb/host_model.sv ----
// host side: one-cycle read and write strobes on the register port
// assumes the design samples on the rising edge of clk
module host_model
(
   input  wire logic        clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata_q,
   input  wire logic        reg_rvalid_q
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      // released data never shows the last word
      reg_wdata = ~d;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      int n;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      n        = 0;
      while (!reg_rvalid_q && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      d = reg_rvalid_q ? reg_rdata_q : 16'hXXXX;
      @(negedge clk);
   endtask
endmodule

// ---- tb/test_charger_option_registers.sv ----
// self-checking bench for the charger option registers
// inputs change at the falling edge; short deglitch counts in sim
module test_charger_option_registers
   import charger_option_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SH = 20;
   localparam int LG = 60;
   logic        clk, rst, wr, rd, rvalid, det, oc, dchg, ok, sw_a, sw_r;
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, rv, chg_reg, dis_reg, pin, chg, dis;
   int          num_errors = 0;
   int          check_count = 0;
   charger_option_registers #(.SHORT_CYC(SH), .LONG_CYC(LG)) dut (
      .clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .reg_rdata_q(rdata),
      .reg_rvalid_q(rvalid), .charge_limit_reg(chg_reg),
      .discharge_limit_reg(dis_reg), .current_limit_pin(pin),
      .adapter_detect_pin(det), .system_overcurrent(oc),
      .charge_limit_q(chg), .discharge_limit_q(dis),
      .discharge_regulation_enable_q(dchg), .adapter_ok_pin_q(ok),
      .adapter_switch_on_q(sw_a), .reverse_block_switch_on_q(sw_r));
   host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .reg_rdata_q(rdata),
      .reg_rvalid_q(rvalid));
   task automatic chk(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic ins(input logic e30, input logic o);
      det = 1'b1;
      repeat (30) @(negedge clk);
      chk("early ok", {13'h0000, ok, sw_a, sw_r},
          {13'h0000, {3{e30}}});
      repeat (40) @(negedge clk);
      chk("late ok", {15'h0000, ok & sw_a & sw_r}, 16'h0001);
      host.rd(OPT3_ADDR, rv);
      chk("present", rv & 16'h0800, 16'h0800);
      oc  = o;
      det = 1'b0;
      repeat (10) @(negedge clk);
      chk("drop ok", {15'h0000, ok}, 16'h0000);
      oc  = 1'b0;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(negedge clk);
      num_errors++;
      finish_test();
   end
   initial
   begin
      rst     = 1'b1;
      det     = 1'b0;
      oc      = 1'b0;
      chg_reg = 16'h0009;
      dis_reg = 16'h0030;
      pin     = 16'h0005;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      host.rd(OPT3_ADDR, rv);
      chk("opt3 reset", rv, 16'h1240);
      host.rd(OPT2_ADDR, rv);
      chk("opt2 reset", rv, 16'h0384);
      chk("chg pin", chg, 16'h0005);
      host.wr(OPT2_ADDR, 16'hFF7F);
      host.rd(OPT2_ADDR, rv);
      chk("opt2 write", rv, 16'h0304);
      chk("chg reg", chg, 16'h0009);
      chk("dis reg", dis, 16'h0030);
      host.wr(OPT2_ADDR, 16'h0080);
      chk("dis pin", dis, 16'h0005);
      pin = 16'h0040;
      repeat (2) @(negedge clk);
      chk("chg min reg", chg, 16'h0009);
      chk("dis min reg", dis, 16'h0030);
      pin = 16'h0005;
      host.rd(8'h00, rv);
      chk("unmapped", rv, 16'h0000);
      host.wr(OPT3_ADDR, 16'hFFFF);
      host.rd(OPT3_ADDR, rv);
      chk("opt3 write", rv, 16'h97FC);
      chk("dchg on", {15'h0000, dchg}, 16'h0001);
      host.wr(OPT3_ADDR, 16'h1240);
      chk("dchg off", {15'h0000, dchg}, 16'h0000);
      ins(1'b1, 1'b0);
      ins(1'b0, 1'b0);
      host.wr(OPT3_ADDR, 16'h0240);
      ins(1'b1, 1'b1);
      ins(1'b0, 1'b0);
      finish_test();
   end
endmodule
bind charger_option_registers charger_option_monitor #(
   .LIM_W(LIM_W), .SHORT_CYC(SHORT_CYC)) mon (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q), .charge_limit_reg(charge_limit_reg),
   .current_limit_pin(current_limit_pin),
   .adapter_detect_pin(adapter_detect_pin),
   .charge_limit_q(charge_limit_q),
   .discharge_regulation_enable_q(discharge_regulation_enable_q),
   .adapter_ok_pin_q(adapter_ok_pin_q),
   .adapter_switch_on_q(adapter_switch_on_q),
   .reverse_block_switch_on_q(reverse_block_switch_on_q));
